// File: verilog/brownout_and_reset_cause_logic.sv
// Purpose: brown-out mode control, start/wake gating, reset-cause flags
// Assumes: single 250 MHz clock, APB register access, analog inputs async
// Notes: state held in one packed struct, registered by one process

// Overview of operation
// - decode two-bit mode into four modes
// - mode 11: sleep protected, start waits
// - mode 10: off in sleep, waits
// - mode 01: soft enable, no start wait
// - soft mode protects after ready; readable
// - two-bit field selects trip level
// - trip only after debounce time elapses
// - erase forces 2.45V, aborts, no reset
// - cause register holds eight ordered flags
// - reset sets only its own flag
// - software set stores, no reset
// - low-voltage mode forces pin reset
// - refuse clearing low-voltage bit in mode
module brownout_and_reset_cause_logic import bor_pkg::*; #(
	parameter int DEB_CYCLES = DEBOUNCE_CYC
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [31:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic [31:0] o_prdata,
	// analog brown-out circuit (async)
	input wire logic i_vdd_low,
	input wire logic i_bor_ready,
	output logic o_bor_enable,
	output logic [1:0] o_bor_level,
	// external reset pin (async, active low)
	input wire logic i_ext_reset_pin_b,
	// core side (same clock)
	input wire core_req_t i_core_req,
	input wire logic i_sleep_req,
	input wire logic i_wake_req,
	input wire logic i_bulk_erase,
	input wire logic i_lowv_prog_active,
	output logic o_cpu_run,
	output logic o_sys_reset,
	output logic o_erase_abort,
	output logic o_irq
);
	typedef struct packed {
		seq_t fsm;
		logic [7:0] prot_cfg;
		logic [7:0] bor_cfg;
		logic soft_en;
		logic [7:0] cause;
		logic [2:0] irq_stat;
		logic [2:0] irq_mask;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic vdd_s1;
		logic vdd_s2;
		logic rdy_s1;
		logic rdy_s2;
		logic pin_s1;
		logic pin_s2;
		logic [15:0] deb_cnt;
		logic rdy_q;
		logic [7:0] req_q;
		logic sys_reset;
		logic cpu_run;
		logic bor_en;
		logic [1:0] bor_lvl;
		logic erase_abort;
		logic irq;
	} state_t;

	state_t st_reg;
	state_t st_next;

	bor_mode_t mode;
	logic protect;
	logic deb_done;
	logic trip;
	logic pin_rst;
	logic [7:0] req;
	logic [7:0] req_rise;
	logic wr;
	logic rd_setup;
	logic hit;
	logic [7:0] rd_val;
	logic [2:0] ev;
	logic [7:0] cfg_w;

	// mode decode and protection gating
	always_comb begin
		mode = bor_mode_t'(st_reg.bor_cfg[1:0]);
		unique case (mode)
			MODE_ON: protect = 1'b1;
			MODE_NO_SLEEP: protect = (st_reg.fsm != ST_SLEEP);
			MODE_SOFT: protect = st_reg.soft_en & st_reg.rdy_s2;
			MODE_OFF: protect = 1'b0;
		endcase
		if (i_bulk_erase) begin
			protect = 1'b1;
		end
	end

	// debounced trip and merged reset requests
	always_comb begin
		deb_done = (st_reg.deb_cnt >= 16'(DEB_CYCLES));
		trip = protect & st_reg.vdd_s2 & deb_done & ~i_bulk_erase;
		pin_rst = ~st_reg.pin_s2 &
			(st_reg.prot_cfg[LOWV_PROG_BIT] | st_reg.bor_cfg[PIN_EN_BIT]);
		req = 8'h00;
		req[C_STACK_OVF] = i_core_req.stack_ovf;
		req[C_STACK_UNF] = i_core_req.stack_unf;
		req[C_WDT_WINDOW] = i_core_req.wdt_window;
		req[C_WDT] = i_core_req.wdt_timeout;
		req[C_PIN] = pin_rst;
		req[C_INSTR] = i_core_req.reset_instr;
		req[C_BOR] = trip;
		req_rise = req & ~st_reg.req_q;
	end

	// apb decode and read mux
	always_comb begin
		wr = i_psel & i_penable & i_pwrite & st_reg.pready;
		rd_setup = i_psel & ~i_penable & ~st_reg.pready;
		hit = 1'b1;
		rd_val = 8'h00;
		unique case (i_paddr)
			PROT_CFG_ADDR: rd_val = st_reg.prot_cfg;
			BOR_CFG_ADDR: rd_val = st_reg.bor_cfg;
			BOR_CTRL_ADDR: begin
				rd_val[SOFT_EN_BIT] = st_reg.soft_en;
				rd_val[READY_BIT] = st_reg.rdy_s2;
			end
			CAUSE_ADDR: rd_val = st_reg.cause;
			IRQ_STAT_ADDR: rd_val = {5'h00, st_reg.irq_stat};
			IRQ_MASK_ADDR: rd_val = {5'h00, st_reg.irq_mask};
			default: hit = 1'b0;
		endcase
	end

	// next-state logic
	always_comb begin
		st_next = st_reg;
		ev = 3'h0;
		cfg_w = st_reg.prot_cfg;

		// two-flop synchronisers for async inputs
		st_next.vdd_s1 = i_vdd_low;
		st_next.vdd_s2 = st_reg.vdd_s1;
		st_next.rdy_s1 = i_bor_ready;
		st_next.rdy_s2 = st_reg.rdy_s1;
		st_next.pin_s1 = i_ext_reset_pin_b;
		st_next.pin_s2 = st_reg.pin_s1;
		st_next.rdy_q = st_reg.rdy_s2;
		st_next.req_q = req;

		// low-supply debounce counter, saturating
		if (!(protect & st_reg.vdd_s2)) begin
			st_next.deb_cnt = 16'h0000;
		end else if (!deb_done) begin
			st_next.deb_cnt = st_reg.deb_cnt + 16'h0001;
		end

		// apb response, one wait-free access phase
		st_next.pready = rd_setup;
		if (rd_setup) begin
			st_next.pslverr = ~hit;
			st_next.prdata = {24'h000000, rd_val};
		end else if (st_reg.pready) begin
			st_next.pslverr = 1'b0;
			st_next.prdata = 32'h0000_0000;
		end

		// register writes
		if (wr && hit) begin
			unique case (i_paddr)
				PROT_CFG_ADDR: begin
					cfg_w = (st_reg.prot_cfg & ~PROT_CFG_WMASK) |
						(i_pwdata[7:0] & PROT_CFG_WMASK);
					if (i_lowv_prog_active) begin
						cfg_w[LOWV_PROG_BIT] = st_reg.prot_cfg[LOWV_PROG_BIT];
					end
					st_next.prot_cfg = cfg_w;
				end
				BOR_CFG_ADDR: st_next.bor_cfg = {3'h0, i_pwdata[4:0]};
				BOR_CTRL_ADDR: st_next.soft_en = i_pwdata[SOFT_EN_BIT];
				CAUSE_ADDR: st_next.cause = i_pwdata[7:0];
				IRQ_STAT_ADDR: st_next.irq_stat = st_reg.irq_stat & ~i_pwdata[2:0];
				IRQ_MASK_ADDR: st_next.irq_mask = i_pwdata[2:0];
				default: st_next.pslverr = st_reg.pslverr;
			endcase
		end

		// hardware sets its own cause flag, set wins over clear
		st_next.cause = st_next.cause | req_rise;

		// events: trip, erase abort, ready rising
		ev[I_TRIP] = req_rise[C_BOR];
		ev[I_ABORT] = i_bulk_erase & st_reg.vdd_s2 & deb_done & ~st_reg.erase_abort;
		ev[I_READY] = st_reg.rdy_s2 & ~st_reg.rdy_q;
		st_next.irq_stat = st_next.irq_stat | ev;
		st_next.irq = |(st_next.irq_stat & st_next.irq_mask);

		// erase abort level, no reset raised
		st_next.erase_abort = i_bulk_erase & (st_reg.erase_abort | ev[I_ABORT]);

		// analog enable and level
		st_next.bor_en = protect | (mode == MODE_SOFT && st_reg.soft_en);
		st_next.bor_lvl = i_bulk_erase ? LEVEL_ERASE : st_reg.bor_cfg[3:2];

		// merged internal reset
		st_next.sys_reset = |req;

		// start-up and sleep sequencing
		unique case (st_reg.fsm)
			ST_START: begin
				if (mode == MODE_SOFT || mode == MODE_OFF) begin
					st_next.fsm = ST_RUN;
				end else if (st_reg.rdy_s2 && !st_reg.vdd_s2) begin
					st_next.fsm = ST_RUN;
				end
			end
			ST_RUN: begin
				if (i_sleep_req) begin
					st_next.fsm = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (i_wake_req) begin
					st_next.fsm = (mode == MODE_NO_SLEEP) ? ST_WAKE : ST_RUN;
				end
			end
			ST_WAKE: begin
				if (st_reg.rdy_s2) begin
					st_next.fsm = ST_RUN;
				end
			end
		endcase
		if (|req) begin
			st_next.fsm = ST_START;
		end
		st_next.cpu_run = (st_next.fsm == ST_RUN);
	end

	// state register
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_reg <= '{
				fsm: ST_START,
				prot_cfg: PROT_CFG_RST,
				bor_cfg: BOR_CFG_RST,
				soft_en: 1'b0,
				cause: CAUSE_RST,
				irq_stat: IRQ_RST,
				irq_mask: IRQ_RST,
				pready: 1'b0,
				pslverr: 1'b0,
				prdata: 32'h0000_0000,
				vdd_s1: 1'b0,
				vdd_s2: 1'b0,
				rdy_s1: 1'b0,
				rdy_s2: 1'b0,
				pin_s1: 1'b1,
				pin_s2: 1'b1,
				deb_cnt: 16'h0000,
				rdy_q: 1'b0,
				req_q: 8'h00,
				sys_reset: 1'b1,
				cpu_run: 1'b0,
				bor_en: 1'b0,
				bor_lvl: 2'h0,
				erase_abort: 1'b0,
				irq: 1'b0
			};
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from state
	assign o_pready = st_reg.pready;
	assign o_pslverr = st_reg.pslverr;
	assign o_prdata = st_reg.prdata;
	assign o_bor_enable = st_reg.bor_en;
	assign o_bor_level = st_reg.bor_lvl;
	assign o_cpu_run = st_reg.cpu_run;
	assign o_sys_reset = st_reg.sys_reset;
	assign o_erase_abort = st_reg.erase_abort;
	assign o_irq = st_reg.irq;
endmodule : brownout_and_reset_cause_logic

// File: pkg/bor_pkg.sv
// Purpose: constants and types for the brown-out and reset-cause block
// Assumes: APB slave with 32-bit data, one word per register
// Notes: indices are register numbers; byte address is four times index
package bor_pkg;
	// register indices and byte addresses
	localparam logic [23:0] PROT_CFG_IDX = 24'h300007;
	localparam logic [23:0] BOR_CFG_IDX = 24'h000000;
	localparam logic [23:0] BOR_CTRL_IDX = 24'h000001;
	localparam logic [23:0] CAUSE_IDX = 24'h000002;
	localparam logic [23:0] IRQ_STAT_IDX = 24'h000003;
	localparam logic [23:0] IRQ_MASK_IDX = 24'h000004;
	localparam logic [31:0] PROT_CFG_ADDR = {6'h00, PROT_CFG_IDX, 2'h0};
	localparam logic [31:0] BOR_CFG_ADDR = {6'h00, BOR_CFG_IDX, 2'h0};
	localparam logic [31:0] BOR_CTRL_ADDR = {6'h00, BOR_CTRL_IDX, 2'h0};
	localparam logic [31:0] CAUSE_ADDR = {6'h00, CAUSE_IDX, 2'h0};
	localparam logic [31:0] IRQ_STAT_ADDR = {6'h00, IRQ_STAT_IDX, 2'h0};
	localparam logic [31:0] IRQ_MASK_ADDR = {6'h00, IRQ_MASK_IDX, 2'h0};
	// field positions
	localparam int LOWV_PROG_BIT = 5;
	localparam int PIN_EN_BIT = 4;
	localparam int SOFT_EN_BIT = 7;
	localparam int READY_BIT = 0;
	// reset values (blank device: config bits read one)
	localparam logic [7:0] PROT_CFG_RST = 8'hFF;
	localparam logic [7:0] PROT_CFG_WMASK = 8'h37;
	localparam logic [7:0] BOR_CFG_RST = 8'h1F;
	localparam logic [7:0] CAUSE_RST = 8'h02;
	localparam logic [2:0] IRQ_RST = 3'h0;
	// brown-out modes of the two-bit mode field
	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_SOFT = 2'b01,
		MODE_NO_SLEEP = 2'b10,
		MODE_ON = 2'b11
	} bor_mode_t;
	// level code forced while bulk erase runs (2.45V trip)
	localparam logic [1:0] LEVEL_ERASE = 2'b11;
	// reset-cause bit positions, highest to lowest
	localparam int C_STACK_OVF = 7;
	localparam int C_STACK_UNF = 6;
	localparam int C_WDT_WINDOW = 5;
	localparam int C_WDT = 4;
	localparam int C_PIN = 3;
	localparam int C_INSTR = 2;
	localparam int C_POWER = 1;
	localparam int C_BOR = 0;
	// interrupt status bits
	localparam int I_TRIP = 0;
	localparam int I_ABORT = 1;
	localparam int I_READY = 2;
	// timing
	localparam int CLK_MHZ = 250;
	localparam int DEBOUNCE_NS = 1000;
	localparam int DEBOUNCE_CYC = (DEBOUNCE_NS * CLK_MHZ) / 1000;
	// sequencer states
	typedef enum logic [1:0] {
		ST_START = 2'b00,
		ST_RUN = 2'b01,
		ST_SLEEP = 2'b10,
		ST_WAKE = 2'b11
	} seq_t;
	// reset request sources from core logic
	typedef struct packed {
		logic stack_ovf;
		logic stack_unf;
		logic wdt_window;
		logic wdt_timeout;
		logic reset_instr;
	} core_req_t;
endpackage : bor_pkg

// File: verification/bor_chk.sv
// Purpose: port checker for the brown-out and reset-cause block
// Assumes: one clock, async active-low reset
// Notes: bound to the top module at the foot
module bor_chk import bor_pkg::*; (
	// inputs
	input wire logic i_clk_sys, i_rst_b, i_psel, i_penable, i_pwrite,
	input wire logic [31:0] i_paddr, i_pwdata,
	input wire logic i_vdd_low, i_bor_ready, i_ext_reset_pin_b,
	input wire core_req_t i_core_req,
	input wire logic i_sleep_req, i_wake_req, i_bulk_erase, i_lowv_prog_active,
	// outputs
	input wire logic o_pready, o_pslverr,
	input wire logic [31:0] o_prdata,
	input wire logic o_bor_enable,
	input wire logic [1:0] o_bor_level,
	input wire logic o_cpu_run, o_sys_reset, o_erase_abort, o_irq
);
	default clocking @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_b);
	// config mirror from apb writes: either bit arms the pin reset
	logic apb_wr;
	logic lowv_m;
	logic pin_en_m;
	logic pin_armed;
	assign apb_wr = i_psel && i_penable && i_pwrite && o_pready;
	assign pin_armed = lowv_m || pin_en_m;
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			lowv_m <= PROT_CFG_RST[LOWV_PROG_BIT];
			pin_en_m <= BOR_CFG_RST[PIN_EN_BIT];
		end else if (apb_wr && i_paddr == PROT_CFG_ADDR) begin
			lowv_m <= i_pwdata[LOWV_PROG_BIT] || (i_lowv_prog_active && lowv_m);
		end else if (apb_wr && i_paddr == BOR_CFG_ADDR) begin
			pin_en_m <= i_pwdata[PIN_EN_BIT];
		end
	end
	// apb setup phase
	sequence s_setup;
		i_psel && !i_penable;
	endsequence
	property p_rdy;
		s_setup |=> o_pready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("no ready after setup");
	property p_one;
		o_pready |=> !o_pready;
	endproperty
	a_one: assert property (p_one) else $error("ready held too long");
	property p_err;
		o_pslverr |-> o_pready;
	endproperty
	a_err: assert property (p_err) else $error("error without ready");
	// reset merge
	property p_req;
		|i_core_req |=> o_sys_reset;
	endproperty
	a_req: assert property (p_req) else $error("request not merged");
	property p_run;
		o_sys_reset |-> !o_cpu_run;
	endproperty
	a_run: assert property (p_run) else $error("cpu runs in reset");
	property p_pin;
		(!i_ext_reset_pin_b && pin_armed) [*5] |-> o_sys_reset;
	endproperty
	a_pin: assert property (p_pin) else $error("pin reset missed");
	// bulk erase forcing
	property p_ers;
		i_bulk_erase |=> o_bor_enable && o_bor_level == LEVEL_ERASE;
	endproperty
	a_ers: assert property (p_ers) else $error("erase not forced");
	property p_abt;
		$rose(o_erase_abort) |-> !o_sys_reset;
	endproperty
	a_abt: assert property (p_abt) else $error("abort caused reset");
	property p_hold;
		o_erase_abort && i_bulk_erase |=> o_erase_abort;
	endproperty
	a_hold: assert property (p_hold) else $error("abort dropped early");
endmodule : bor_chk

bind brownout_and_reset_cause_logic bor_chk bor_chk_i (.*);

// File: verification/tb_brownout_and_reset_cause_logic.sv
// Purpose: self-checking bench for the brown-out and reset-cause block
// Assumes: debounce shortened to 4, master waits for pready
// Notes: cause flags modelled in an int
module tb_brownout_and_reset_cause_logic import bor_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, vlow = 0, rdy = 1, pin_b = 1;
	logic slp = 0, wk = 0, ers = 0, lv_prog = 0, pr, pe, err, ben, run, srst, abt, irq;
	logic [31:0] pa = 0, pd = 0, q, rd_q;
	logic [1:0] lvl;
	core_req_t req = '0;
	int fails = 0, n_checks = 0, cyc = 0, mc = 2;
	int bits[5] = '{C_STACK_OVF, C_STACK_UNF, C_WDT_WINDOW, C_WDT, C_INSTR};
	always #2 clk = ~clk;
	brownout_and_reset_cause_logic #(.DEB_CYCLES(4)) brownout_and_reset_cause_logic_i (
		.i_clk_sys(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(pa), .i_pwdata(pd), .o_pready(pr), .o_pslverr(pe), .o_prdata(q),
		.i_vdd_low(vlow), .i_bor_ready(rdy), .o_bor_enable(ben), .o_bor_level(lvl),
		.i_ext_reset_pin_b(pin_b), .i_core_req(req), .i_sleep_req(slp), .i_wake_req(wk),
		.i_bulk_erase(ers), .i_lowv_prog_active(lv_prog), .o_cpu_run(run), .o_sys_reset(srst),
		.o_erase_abort(abt), .o_irq(irq));
	task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s exp %h got %h", nm, e, s);
		end
	endtask : chk
	// one apb transfer
	task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwr <= w;
		pa <= a;
		pd <= d;
		@(posedge clk);
		pen <= 1;
		do @(posedge clk); while (pr !== 1'b1);
		rd_q = q;
		err = pe;
		psel <= 0;
		pen <= 0;
	endtask : bus
	task automatic rd(logic [31:0] a, logic [31:0] e, string nm);
		bus(0, a, 0);
		chk(nm, rd_q, e);
	endtask : rd
	task automatic give_verdict();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : give_verdict
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			give_verdict();
		end
	end
	initial begin
		void'($urandom(32'hEF9B));
		repeat (4) @(posedge clk);
		rst_b <= 1;
		rd(PROT_CFG_ADDR, 32'hFF, "prot");
		rd(BOR_CFG_ADDR, 32'h1F, "cfg");
		rd(32'h14, 0, "unmapped");
		chk("slverr", err, 1);
		// each core source sets only its flag
		foreach (bits[i]) begin
			req <= core_req_t'(5'h10 >> i);
			@(posedge clk);
			req <= '0;
			repeat (4) @(posedge clk);
			mc |= 1 << bits[i];
			rd(CAUSE_ADDR, mc, "cause");
		end
		mc = $urandom & 8'hFF;
		bus(1, CAUSE_ADDR, mc);
		repeat (3) @(posedge clk);
		chk("soft set", srst, 0);
		rd(CAUSE_ADDR, mc, "cause");
		mc = 0;
		bus(1, CAUSE_ADDR, 0);
		rd(CAUSE_ADDR, 0, "cleared");
		$display("cause test done");
		lv_prog <= 1;
		bus(1, PROT_CFG_ADDR, 0);
		rd(PROT_CFG_ADDR, 32'hE8, "lvp kept");
		lv_prog <= 0;
		bus(1, PROT_CFG_ADDR, 32'hDF);
		rd(PROT_CFG_ADDR, 32'hDF, "lvp off");
		bus(1, PROT_CFG_ADDR, 32'hFF);
		pin_b <= 0;
		repeat (6) @(posedge clk);
		chk("pin", srst, 1);
		pin_b <= 1;
		mc |= 8;
		repeat (6) @(posedge clk);
		rd(CAUSE_ADDR, mc, "pin flag");
		// pin ignored with both enabling bits clear
		bus(1, PROT_CFG_ADDR, 32'hDF);
		bus(1, BOR_CFG_ADDR, 32'h0F);
		pin_b <= 0;
		repeat (6) @(posedge clk);
		chk("pin ignored", srst, 0);
		pin_b <= 1;
		repeat (3) @(posedge clk);
		bus(1, PROT_CFG_ADDR, 32'hFF);
		$display("config test done");
		for (int m = 0; m < 4; m++) begin
			bus(1, BOR_CFG_ADDR, 32'h1C | m);
			repeat (3) @(posedge clk);
			chk("mode", ben, m[1]);
		end
		bus(1, BOR_CFG_ADDR, 32'h1D);
		bus(1, BOR_CTRL_ADDR, 32'h80);
		repeat (3) @(posedge clk);
		chk("soft", ben, 1);
		rd(BOR_CTRL_ADDR, 32'h81, "ctrl");
		bus(1, BOR_CFG_ADDR, 32'h10);
		$display("mode test done");
		bus(1, IRQ_MASK_ADDR, 2);
		ers <= 1;
		repeat (2) @(posedge clk);
		chk("erase", {ben, lvl}, 3'h7);
		vlow <= 1;
		repeat (12) @(posedge clk);
		chk("abort", {abt, srst, irq}, 3'h5);
		ers <= 0;
		vlow <= 0;
		bus(1, IRQ_MASK_ADDR, 0);
		@(posedge clk);
		chk("masked", irq, 0);
		bus(1, IRQ_STAT_ADDR, 2);
		bus(1, IRQ_MASK_ADDR, 2);
		repeat (2) @(posedge clk);
		chk("irq clr", irq, 0);
		rd(CAUSE_ADDR, mc, "no bor");
		$display("erase test done");
		bus(1, BOR_CFG_ADDR, 32'h1F);
		vlow <= 1;
		repeat (2) @(posedge clk);
		vlow <= 0;
		repeat (8) @(posedge clk);
		chk("dip", srst, 0);
		vlow <= 1;
		repeat (10) @(posedge clk);
		chk("trip", srst, 1);
		vlow <= 0;
		mc |= 1;
		repeat (10) @(posedge clk);
		rd(CAUSE_ADDR, mc, "bor flag");
		$display("brown-out test done");
		// sleep and wake in mode 10: off in sleep, wake waits for ready
		bus(1, BOR_CFG_ADDR, 32'h1E);
		slp <= 1;
		@(posedge clk);
		slp <= 0;
		repeat (2) @(posedge clk);
		chk("sleep run", run, 0);
		chk("sleep off", ben, 0);
		rdy <= 0;
		repeat (3) @(posedge clk);
		wk <= 1;
		@(posedge clk);
		wk <= 0;
		repeat (4) @(posedge clk);
		chk("wake held", run, 0);
		rdy <= 1;
		repeat (5) @(posedge clk);
		chk("wake ready", run, 1);
		// mode 11: protected in sleep, wake not delayed
		bus(1, BOR_CFG_ADDR, 32'h1F);
		slp <= 1;
		@(posedge clk);
		slp <= 0;
		repeat (2) @(posedge clk);
		chk("sleep kept", {run, ben}, 2'b01);
		rdy <= 0;
		repeat (3) @(posedge clk);
		wk <= 1;
		@(posedge clk);
		wk <= 0;
		@(posedge clk);
		chk("wake fast", run, 1);
		$display("sleep test done");
		// mid-run reset: start-up waits for ready
		rst_b <= 0;
		repeat (2) @(posedge clk);
		rst_b <= 1;
		mc = 1 << C_POWER;
		repeat (4) @(posedge clk);
		chk("start held", run, 0);
		rd(CAUSE_ADDR, mc, "power flag");
		rdy <= 1;
		repeat (5) @(posedge clk);
		chk("start run", run, 1);
		$display("restart test done");
		give_verdict();
	end
endmodule : tb_brownout_and_reset_cause_logic
